// File: hw/dlc_channel.sv
// Channel end: fetches 16-byte descriptors, moves data, waits, branches.
// Assumes the memory end answers each req with a one-cycle ack.
//
// What this block does
// - Descriptors are exactly sixteen bytes
// - At most one interrupt per operation
// - Lists and status live in host memory
// - Entries run in order unless branched
// - Branch on transfer or on nop
// - One channel instance per data stream
// - Optional event channel reports others' events
// - Conditional wait on status bits
// - Outside party drives external status bits
// - Input, output, nop may branch conditionally
// - Lowest address byte is least significant
// - Reserved fields written as zero
// - Reserved fields ignored when read
// - Alignment bits of pointers are reserved
// - Next pointer taken as 16-byte aligned
// - Simple target executing host commands
`timescale 1ns/1ps
module dlc_channel #(
    parameter int EVENT_CHANNEL = 0
) (
    input  wire logic                sys_clk,
    input  wire logic                rst_b,
    dlc_link_if.channel              link,
    input  wire logic                run,
    input  wire logic [31:0]         next_descriptor_pointer,
    input  wire logic                load_pointer,
    input  wire logic [7:0]          event_in,
    output logic                     active,
    output logic                     irq,
    output logic [31:0]              descriptor_list_pointer,
    output logic [7:0]               status
);
    ////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_FETCH = 3'b001,
        ST_WAIT  = 3'b010,
        ST_MOVE  = 3'b011,
        ST_STAT  = 3'b100,
        ST_NEXT  = 3'b101
    } state_e;

    typedef struct packed {
        state_e      st;
        logic [1:0]  wcnt;
        logic [31:0] w0;
        logic [31:0] w1;
        logic [31:0] w2;
        logic [31:0] w3;
        logic [31:0] ptr;
        logic [15:0] left;
        logic [31:0] daddr;
        logic        req;
        logic        wr;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic        irq;
        logic        irq_done;
        logic [7:0]  status;
    } chan_s;

    chan_s cur_ff;
    chan_s nxt_ff;

    logic [3:0]  cmd;
    logic [7:0]  live_status;
    logic        wait_hit;
    logic        br_hit;
    logic        last_beat;

    assign live_status = cur_ff.status | link.ext_status
                         | (EVENT_CHANNEL != 0 ? event_in : 8'h00);
    assign cmd = cur_ff.w0[dlc_pkg::CMD_LSB +: 4];
    assign wait_hit = cur_ff.w0[dlc_pkg::WAIT_EN_BIT]
        && ((live_status & cur_ff.w1[dlc_pkg::WT_MASK_LSB +: 8])
            != cur_ff.w1[dlc_pkg::WT_VAL_LSB +: 8]);
    assign br_hit = cur_ff.w0[dlc_pkg::BR_EN_BIT]
        && ((live_status & cur_ff.w1[dlc_pkg::BR_MASK_LSB +: 8])
            == (cur_ff.w1[7:0] & cur_ff.w1[dlc_pkg::BR_MASK_LSB +: 8]));
    assign last_beat = (cur_ff.left <= 16'h0004);

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.irq = 1'b0;
        unique case (cur_ff.st)
            ST_IDLE: begin
                nxt_ff.req = 1'b0;
                if (load_pointer) begin
                    nxt_ff.ptr = {next_descriptor_pointer[31:4], 4'h0};
                end
                if (run) begin
                    nxt_ff.st       = ST_FETCH;
                    nxt_ff.wcnt     = dlc_pkg::WORD_CNT_ZERO;
                    nxt_ff.irq_done = 1'b0;
                    nxt_ff.req      = 1'b1;
                    nxt_ff.wr       = 1'b0;
                    nxt_ff.addr     = nxt_ff.ptr;
                end
            end
            ST_FETCH: begin
                if (link.ack) begin
                    unique case (cur_ff.wcnt)
                        2'h0: nxt_ff.w0 = link.rdata;
                        2'h1: nxt_ff.w1 = link.rdata;
                        2'h2: nxt_ff.w2 = link.rdata;
                        2'h3: nxt_ff.w3 = link.rdata;
                    endcase
                    nxt_ff.wcnt = cur_ff.wcnt + 2'h1;
                    nxt_ff.addr = cur_ff.addr + 32'h0000_0004;
                    if (cur_ff.wcnt == dlc_pkg::WORD_CNT_LAST) begin
                        nxt_ff.req = 1'b0;
                        nxt_ff.st  = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                if (!run) begin
                    nxt_ff.st = ST_IDLE;
                end else if (!wait_hit) begin
                    nxt_ff.daddr = {cur_ff.w2[31:2], 2'h0};
                    nxt_ff.left  = cur_ff.w0[dlc_pkg::LEN_MSB:0];
                    if (cmd == dlc_pkg::CMD_STOP) begin
                        nxt_ff.st = ST_IDLE;
                    end else if ((cmd == dlc_pkg::CMD_NOP)
                                 || (cur_ff.w0[15:0]
                                     == dlc_pkg::ZERO_LEN)) begin
                        nxt_ff.st = ST_STAT;
                    end else begin
                        nxt_ff.st    = ST_MOVE;
                        nxt_ff.req   = 1'b1;
                        nxt_ff.wr    = (cmd == dlc_pkg::CMD_INPUT);
                        nxt_ff.addr  = {cur_ff.w2[31:2], 2'h0};
                        nxt_ff.wdata = cur_ff.w3;
                    end
                end
            end
            ST_MOVE: begin
                if (link.ack) begin
                    nxt_ff.addr = cur_ff.addr + 32'h0000_0004;
                    nxt_ff.left = last_beat ? dlc_pkg::ZERO_LEN
                                            : cur_ff.left - 16'h0004;
                    if (last_beat) begin
                        nxt_ff.req = 1'b0;
                        nxt_ff.st  = ST_STAT;
                    end
                end
            end
            ST_STAT: begin
                if (!cur_ff.req) begin
                    nxt_ff.req   = 1'b1;
                    nxt_ff.wr    = 1'b1;
                    nxt_ff.addr  = cur_ff.ptr + 32'h0000_000C;
                    nxt_ff.wdata = {24'h00_0000, live_status};
                end else if (link.ack) begin
                    nxt_ff.req = 1'b0;
                    nxt_ff.st  = ST_NEXT;
                end
            end
            ST_NEXT: begin
                if (cur_ff.w0[dlc_pkg::IRQ_BIT] && !cur_ff.irq_done) begin
                    nxt_ff.irq      = 1'b1;
                    nxt_ff.irq_done = 1'b1;
                end
                if (br_hit && (cmd != dlc_pkg::CMD_STOP)) begin
                    nxt_ff.ptr = {cur_ff.w3[31:4], 4'h0};
                end else begin
                    nxt_ff.ptr = cur_ff.ptr + dlc_pkg::DESC_STEP;
                end
                nxt_ff.st   = run ? ST_FETCH : ST_IDLE;
                nxt_ff.wcnt = dlc_pkg::WORD_CNT_ZERO;
                nxt_ff.req  = run;
                nxt_ff.wr   = 1'b0;
                nxt_ff.addr = nxt_ff.ptr;
            end
            default: nxt_ff.st = ST_IDLE;
        endcase
        nxt_ff.status = {6'h00, (nxt_ff.st != ST_IDLE), run};
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////
    assign link.req              = cur_ff.req;
    assign link.wr               = cur_ff.wr;
    assign link.addr             = cur_ff.addr;
    assign link.wdata            = cur_ff.wdata;
    assign active                = cur_ff.status[1];
    assign irq                   = cur_ff.irq;
    assign descriptor_list_pointer = cur_ff.ptr;
    assign status                = cur_ff.status;
endmodule : dlc_channel

// File: hw/dlc_pkg.sv
// Package: shared constants of the descriptor list DMA channel.
// Assumes a single sys_clk domain and little-endian 32-bit memory words.
package dlc_pkg;
    localparam int          ADDR_W        = 32;
    localparam int          DATA_W        = 32;
    localparam int          DESC_BYTES    = 16;
    localparam int          DESC_WORDS    = 4;
    localparam int          ALIGN_BITS    = 4;
    localparam int          STAT_W        = 8;
    localparam logic [31:0] DESC_STEP     = 32'h0000_0010;
    localparam logic [1:0]  WORD_CNT_LAST = 2'h3;
    localparam logic [1:0]  WORD_CNT_ZERO = 2'h0;
    // Command codes, bits 31:28 of word 0
    localparam logic [3:0]  CMD_OUTPUT    = 4'h0;
    localparam logic [3:0]  CMD_INPUT     = 4'h1;
    localparam logic [3:0]  CMD_NOP       = 4'h2;
    localparam logic [3:0]  CMD_STOP      = 4'h3;
    // Word 0 field positions
    localparam int          CMD_LSB       = 28;
    localparam int          IRQ_BIT       = 27;
    localparam int          BR_EN_BIT     = 26;
    localparam int          WAIT_EN_BIT   = 25;
    localparam int          LEN_MSB       = 15;
    // Word 1: bits 23:16 mask, 7:0 value for branch; 31:24 mask, 15:8 value for wait
    localparam int          BR_MASK_LSB   = 16;
    localparam int          WT_MASK_LSB   = 24;
    localparam int          WT_VAL_LSB    = 8;
    localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
    localparam logic [15:0] ZERO_LEN      = 16'h0000;
endpackage : dlc_pkg

// File: hw/dlc_link_if.sv
// Interface: memory port between the channel and the host memory side.
// Assumes one clock; a request is taken when req and ack meet.
`timescale 1ns/1ps
interface dlc_link_if;
    logic        req;
    logic        wr;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        ack;
    logic [31:0] rdata;
    logic [7:0]  ext_status;

    modport channel (
        output req,
        output wr,
        output addr,
        output wdata,
        input  ack,
        input  rdata,
        input  ext_status
    );
    modport memory (
        input  req,
        input  wr,
        input  addr,
        input  wdata,
        output ack,
        output rdata,
        output ext_status
    );
endinterface : dlc_link_if

// File: hw/dlc_memory.sv
// Host end: answers channel requests from a word array standing for
// system memory, and drives the external status bits.
// Assumes host software loads the array through the user port.
`timescale 1ns/1ps
module dlc_memory #(
    parameter int DEPTH_W = 8
) (
    input  wire logic                sys_clk,
    input  wire logic                rst_b,
    dlc_link_if.memory               link,
    input  wire logic                host_we,
    input  wire logic [DEPTH_W-1:0]  host_addr,
    input  wire logic [31:0]         host_wdata,
    input  wire logic [7:0]          host_status,
    output logic [31:0]              host_rdata
);
    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
        logic [7:0]  ext;
        logic [31:0] hrd;
    } mem_s;

    mem_s cur_ff;
    mem_s nxt_ff;
    logic [31:0] mem_ff [2**DEPTH_W];
    logic [DEPTH_W-1:0] widx;

    assign widx = link.addr[DEPTH_W+1:2];

    always_comb begin
        nxt_ff       = cur_ff;
        nxt_ff.ack   = link.req && !cur_ff.ack;
        nxt_ff.rdata = mem_ff[widx];
        nxt_ff.ext   = host_status;
        nxt_ff.hrd   = mem_ff[host_addr];
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (link.req && link.wr && !cur_ff.ack) begin
            mem_ff[widx] <= link.wdata;
        end else if (host_we) begin
            mem_ff[host_addr] <= host_wdata;
        end
    end

    assign link.ack        = cur_ff.ack;
    assign link.rdata      = cur_ff.rdata;
    assign link.ext_status = cur_ff.ext;
    assign host_rdata      = cur_ff.hrd;
endmodule : dlc_memory

// File: dv/dlc_link_monitor.sv
// Checker: link handshake and descriptor fetch order between both ends.
// Assumes instantiation beside the link interface, one clock domain.
`timescale 1ns/1ps
module dlc_link_monitor (
    input wire logic        sys_clk,
    input wire logic        rst_b,
    input wire logic        req,
    input wire logic        wr,
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic        ack,
    input wire logic [31:0] rdata,
    input wire logic [7:0]  ext_status
);
    logic [1:0]  rd_cnt_ff;
    logic [31:0] prev_ff;
    logic [31:0] start_ff;
    logic        br_ff;
    logic        seen_ff;
    logic        fetch_ff;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    ////////////////////////////////////////////////////////////////////////
    // Track descriptor reads only; data reads of an output are skipped
    // Any acked write ends the entry, so the next read starts a fetch
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_cnt_ff <= 2'h0;
            prev_ff   <= 32'h0;
            start_ff  <= 32'h0;
            br_ff     <= 1'h0;
            seen_ff   <= 1'h0;
            fetch_ff  <= 1'h1;
        end else if (req && ack && wr) begin
            fetch_ff  <= 1'h1;
        end else if (req && ack && fetch_ff) begin
            rd_cnt_ff <= rd_cnt_ff + 2'h1;
            prev_ff   <= addr;
            if (rd_cnt_ff == 2'h3) begin
                fetch_ff <= 1'h0;
            end
            if (rd_cnt_ff == 2'h0) begin
                start_ff <= addr;
                br_ff    <= rdata[dlc_pkg::BR_EN_BIT];
                seen_ff  <= 1'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_ack_one_later: assert property (req && !ack |=> ack)
        else $error("ack not one cycle after request");
    a_req_held_stable: assert property (req && !ack |=> req &&
        $stable(addr) && $stable(wr) && $stable(wdata))
        else $error("request changed before ack");
    a_ack_after_req: assert property (
        ack |-> $past(req) && !$past(ack))
        else $error("ack without a pending request");
    a_ack_single_pulse: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    a_addr_word_aligned: assert property (req |-> addr[1:0] == 2'h0)
        else $error("link address not word aligned");
    a_fetch_start_aligned: assert property (
        req && !wr && fetch_ff && rd_cnt_ff == 2'h0 |-> addr[3:0] == 4'h0)
        else $error("descriptor fetch not 16-byte aligned");
    a_fetch_word_step: assert property (
        req && !wr && fetch_ff && rd_cnt_ff != 2'h0
        |-> addr == prev_ff + 32'h4)
        else $error("descriptor word out of order");
    a_next_entry_step: assert property (
        req && !wr && fetch_ff && rd_cnt_ff == 2'h0
        && seen_ff && !br_ff |-> addr == start_ff + 32'h10)
        else $error("next entry not sixteen bytes on");

    cover property (req && ack && wr);
    cover property (req && ack && wr && ext_status != 8'h00);
    cover property (req && ack && !wr && rd_cnt_ff == 2'h3);
    cover property (seen_ff && br_ff && req && !wr && rd_cnt_ff == 2'h0);
endmodule : dlc_link_monitor

// File: dv/testbench.sv
// Testbench: both channel ends joined by the link, host-side tasks.
// Assumes memory word index is byte address bits 9:2.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module testbench;
    logic        sys_clk = 1'h0;
    logic        rst_b = 1'h0;
    logic        run = 1'h0;
    logic        load_pointer = 1'h0;
    logic [31:0] next_descriptor_pointer = 32'h0;
    logic        host_we = 1'h0;
    logic [7:0]  host_addr = 8'h0;
    logic [31:0] host_wdata = 32'h0;
    logic [7:0]  host_status = 8'h0;
    logic [7:0]  event_bits = 8'h0;
    logic        active;
    logic        irq;
    logic [31:0] descriptor_list_pointer;
    logic [31:0] host_rdata;
    logic [7:0]  status;
    logic [31:0] first_rd;
    logic        got_rd = 1'h0;
    int          bad_count = 0;
    int          n_checks = 0;
    int          irq_count = 0;
    int          cycles = 0;

    dlc_link_if link ();
    dlc_channel dlc_channel_inst (.sys_clk(sys_clk), .rst_b(rst_b),
        .link(link.channel), .run(run), .load_pointer(load_pointer),
        .next_descriptor_pointer(next_descriptor_pointer),
        .event_in(event_bits), .active(active), .irq(irq), .status(status),
        .descriptor_list_pointer(descriptor_list_pointer));
    dlc_memory dlc_memory_inst (.sys_clk(sys_clk), .rst_b(rst_b),
        .link(link.memory), .host_we(host_we), .host_addr(host_addr),
        .host_wdata(host_wdata), .host_status(host_status),
        .host_rdata(host_rdata));
    dlc_link_monitor dlc_link_monitor_inst (.sys_clk(sys_clk),
        .rst_b(rst_b), .req(link.req), .wr(link.wr), .addr(link.addr),
        .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata),
        .ext_status(link.ext_status));

    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish

    always @(posedge sys_clk) begin
        cycles++;
        if (irq === 1'h1) irq_count++;
        if (link.req === 1'h1 && link.wr === 1'h0 && !got_rd) begin
            first_rd = link.addr;
            got_rd = 1'h1;
        end
        if (cycles == 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    task step;
        @(posedge sys_clk);
        #1;
    endtask : step

    function automatic logic [31:0] w0(input logic [3:0] c,
        input logic [2:0] f, input logic [15:0] n);
        return {c, f, 9'h0, n};
    endfunction : w0

    task put(input logic [31:0] a, input logic [31:0] d);
        host_addr = a[9:2];
        host_wdata = d;
        host_we = 1'h1;
        step();
    endtask : put

    task desc(input logic [31:0] a, d0, d1, d2, d3);
        put(a, d0);
        put(a + 32'h4, d1);
        put(a + 32'h8, d2);
        put(a + 32'hC, d3);
    endtask : desc

    task expect_word(input logic [31:0] a, input logic [31:0] e);
        host_addr = a[9:2];
        step();
        step();
        `CHK(host_rdata, e)
    endtask : expect_word

    task restart;
        rst_b = 1'h0;
        repeat (5) step();
        rst_b = 1'h1;
        got_rd = 1'h0;
        irq_count = 0;
        step();
    endtask : restart

    task start(input logic [31:0] p);
        host_we = 1'h0;
        next_descriptor_pointer = p;
        load_pointer = 1'h1;
        step();
        load_pointer = 1'h0;
        run = 1'h1;
    endtask : start

    task finish_run;
        for (int i = 0; i < 3000; i++) begin
            if (i > 4 && active === 1'h0) break;
            step();
        end
        run = 1'h0;
        step();
    endtask : finish_run

    ////////////////////////////////////////////////////////////////////////
    initial begin
        restart();
        // Output reads, input writes, both ask for an interrupt, then stop
        put(32'h200, 32'hC0DE_0200);
        put(32'h204, 32'hC0DE_0204);
        desc(32'h40, w0(dlc_pkg::CMD_OUTPUT, 3'h4, 16'h8), 32'h0,
            32'h200, 32'hA1B2C3D4);
        desc(32'h50, w0(dlc_pkg::CMD_INPUT, 3'h4, 16'h4), 32'h0,
            32'h240, 32'h11223344);
        desc(32'h60, w0(dlc_pkg::CMD_STOP, 3'h0, 16'h0), 32'h0, 32'h0, 32'h0);
        start(32'h4B);
        finish_run();
        `CHK(first_rd, 32'h40)
        `CHK(irq_count, 1)
        `CHK(descriptor_list_pointer, 32'h60)
        expect_word(32'h200, 32'hC0DE_0200);
        expect_word(32'h204, 32'hC0DE_0204);
        expect_word(32'h4C, 32'h0000_0003);
        expect_word(32'h5C, 32'h0000_0003);
        expect_word(32'h240, 32'h11223344);
        restart();
        // Taken branch on nop, untaken branch on output
        desc(32'h40, w0(dlc_pkg::CMD_NOP, 3'h2, 16'h0), 32'h0001_0001,
            32'h0, 32'h100);
        desc(32'h50, w0(dlc_pkg::CMD_OUTPUT, 3'h0, 16'h4), 32'h0,
            32'h280, 32'hDEAD0000);
        desc(32'h100, w0(dlc_pkg::CMD_OUTPUT, 3'h2, 16'h4), 32'h0001_0000,
            32'h2C0, 32'hBEEF0001);
        desc(32'h110, w0(dlc_pkg::CMD_STOP, 3'h0, 16'h0), 32'h0, 32'h0, 32'h0);
        start(32'h40);
        finish_run();
        `CHK(irq_count, 0)
        `CHK(descriptor_list_pointer, 32'h110)
        expect_word(32'h4C, 32'h0000_0003);
        expect_word(32'h5C, 32'hDEAD0000);
        expect_word(32'h10C, 32'h0000_0003);
        restart();
        // Wait on an external status bit, released by the host side
        event_bits = 8'h40;
        desc(32'h40, w0(dlc_pkg::CMD_OUTPUT, 3'h1, 16'h4), 32'h8000_8000,
            32'h300, 32'h5A5A5A5A);
        desc(32'h50, w0(dlc_pkg::CMD_STOP, 3'h0, 16'h0), 32'h0, 32'h0, 32'h0);
        start(32'h40);
        repeat (60) step();
        `CHK(active, 1'h1)
        `CHK(status, 8'h03)
        expect_word(32'h4C, 32'h5A5A5A5A);
        host_status = 8'h80;
        finish_run();
        expect_word(32'h4C, 32'h0000_0083);
        expect_word(32'h4C, 32'h0000_0083);
        `CHK(descriptor_list_pointer, 32'h50)
        tally_and_finish();
    end
endmodule : testbench
